// File: common/lbb_pkg.sv
// package: constants, encodings and state record of the lcd bank/blink serial slave
package lbb_pkg;

  // ****************************************
  // clocking
  // ****************************************
  localparam int PCLK_HZ = 100000000;
  localparam int DISP_CLK_HZ = 1970; // typical internal display clock

  // ****************************************
  // drive mode encodings
  // ****************************************
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_MUX2 = 2'h2;
  localparam logic [1:0] MODE_MUX3 = 2'h3;
  localparam logic [1:0] MODE_MUX4 = 2'h0;

  // ****************************************
  // command opcodes (fixed upper bits)
  // ****************************************
  localparam logic [3:0] OP_MODE_SET = 4'hC;
  localparam logic [4:0] OP_DEV_SEL = 5'h1C;
  localparam logic [5:0] OP_BANK_SEL = 6'h3E;
  localparam logic [4:0] OP_BLINK_SEL = 5'h1E;

  // ****************************************
  // blink division ratios, row offset and ack bit counts
  // ****************************************
  localparam logic [11:0] BLINK_RATIO1 = 12'h300;
  localparam logic [11:0] BLINK_RATIO2 = 12'h600;
  localparam logic [11:0] BLINK_RATIO3 = 12'hC00;
  localparam logic [1:0] ALT_ROW = 2'h2;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RXB_OFS = 8'h08;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [6:0] SLV_ADDR_RST = 7'h38;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_SKIP} lbb_i2c_st_t;

  // all state of the top module
  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic [2:0] sub_s1;
    logic [2:0] sub_s2;
    lbb_i2c_st_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] last_byte;
    logic ack_oe;
    logic [1:0] mode;
    logic disp_en;
    logic in_bank;
    logic out_bank;
    logic blink_alt;
    logic [1:0] blink_rate;
    logic [2:0] subaddr_cnt;
    logic [15:0] div_cnt;
    logic tick;
    logic [1:0] phase;
    logic [11:0] blink_cnt;
    logic blink_ph;
    logic [1:0] row_sel;
    logic disp_vis;
    logic [1:0] in_row;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lbb_state_t;

endpackage : lbb_pkg

// File: rtl/lbb_top.sv
// lcd bank selection, blinker and write-only two-wire slave receiver with apb access
//
// Function
// - four backplanes: show rows 0,1,2,3 in successive multiplex phases.
// - three backplanes: cycle row selection through rows 0, 1, 2.
// - two backplanes: alternate row selection between rows 0 and 1.
// - static: show only row 0 by default.
// - static with alternate output bank: show row 2 instead of row 0.
// - two backplanes with alternate output bank: show rows 2 and 3.
// - alternate input bank steers incoming data to row 2 or rows 2 and 3.
// - input and output bank choices are held and applied independently.
// - blink rate is display clock divided by 768, 1536, 3072, or off.
// - normal blink mode with a rate set blinks the whole display.
// - alternate-bank blink swaps displayed bank at blink rate in static/two-backplane.
// - data changing while clock high is a bus condition, not a bit.
// - data falling while clock high is detected as start.
// - data rising while clock high is detected as stop.
// - both lines high means idle; no acknowledge driven while idle.
// - addressed device acknowledges its address byte, and a data byte only while the subaddress matches, on the ninth clock pulse.
// - acknowledge pulls low before the ninth pulse and holds through its high phase.
// - slave receiver only; the sole bus output is acknowledge.
// - acknowledge leaves on a dedicated open-drain pin apart from data input.
// - selection depends on slave address, command data and subaddress pins.
// - bank-select 111110: bit1 input bank, bit0 output bank; ignored in 3/4 backplanes.
// - blink-select 11110: bit2 alternate-bank blink, low two bits blink rate.
// - drive mode: 01 static, 10 two, 11 three, 00 four backplanes.
`timescale 1ns/1ps

module lbb_top #(
  parameter logic [15:0] DISP_DIV = 16'(lbb_pkg::PCLK_HZ / lbb_pkg::DISP_CLK_HZ),
  parameter logic [6:0] SLV_ADDR = lbb_pkg::SLV_ADDR_RST
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire bus pins
  input wire logic scl,
  input wire logic sda,
  output logic ack_output_pin,
  output logic ack_output_pin_oe,
  // hardware subaddress straps
  input wire logic hw_subaddr_bit0,
  input wire logic hw_subaddr_bit1,
  input wire logic hw_subaddr_bit2,
  // display side
  output logic [1:0] row_sel,
  output logic disp_visible,
  output logic [1:0] in_row_base
);

  // ****************************************
  // helpers
  // ****************************************
  // half of the blink period in display clock ticks, zero when blinking is off
  function automatic logic [11:0] blink_half(input logic [1:0] rate);
    logic [11:0] r;
    r = 12'h000;
    unique case (rate)
      2'h1: r = lbb_pkg::BLINK_RATIO1 >> 1;
      2'h2: r = lbb_pkg::BLINK_RATIO2 >> 1;
      2'h3: r = lbb_pkg::BLINK_RATIO3 >> 1;
      2'h0: r = 12'h000;
    endcase
    return r;
  endfunction : blink_half

  // bank switching only exists in static and two-backplane modes
  function automatic logic has_banks(input logic [1:0] mode);
    return (mode == lbb_pkg::MODE_STATIC) || (mode == lbb_pkg::MODE_MUX2);
  endfunction : has_banks

  lbb_pkg::lbb_state_t q;
  lbb_pkg::lbb_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic banked;
  logic blinking;
  logic eff_bank;
  logic [1:0] last_phase;
  logic [1:0] cur_phase;
  logic apb_wr;
  logic [7:0] rx_byte;

  // ****************************************
  // bus condition detection
  // ****************************************
  // only the second and third sync stages feed logic; the first is metastability guard
  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = ~q.scl_s2 & q.scl_s3;
  assign start_det = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_det = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign rx_byte = q.shreg;

  // ****************************************
  // display derived terms
  // ****************************************
  assign banked = has_banks(q.mode);
  assign blinking = q.blink_rate != 2'h0;
  assign eff_bank = q.out_bank ^ (q.blink_alt & blinking & q.blink_ph);
  // last multiplex phase of the frame for the current drive mode
  always_comb begin
    unique case (q.mode)
      lbb_pkg::MODE_MUX4: last_phase = 2'h3;
      lbb_pkg::MODE_MUX3: last_phase = 2'h2;
      lbb_pkg::MODE_MUX2: last_phase = 2'h1;
      lbb_pkg::MODE_STATIC: last_phase = 2'h0;
    endcase
  end

  // a phase left over from a longer frame folds to 0 at once, so a mode
  // change never shows a row outside the new frame, not even for one tick
  assign cur_phase = (q.phase > last_phase) ? 2'h0 : q.phase;

  assign apb_wr = psel & penable & pwrite & q.pready;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    // three-flop synchronisers on the bus pins, two-flop on the subaddress straps
    d.sda_s1 = sda;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.scl_s1 = scl;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sub_s1 = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
    d.sub_s2 = q.sub_s1;

    // serial receiver: bits sampled on clock rise, ack changed on clock fall
    if (stop_det) begin
      d.st = lbb_pkg::ST_IDLE;
      d.ack_oe = 1'b0;
      d.bit_cnt = 4'h0;
    end else if (start_det) begin
      d.st = lbb_pkg::ST_ADDR; // repeated start also lands here
      d.ack_oe = 1'b0;
      d.bit_cnt = 4'h0;
    end else if (q.st != lbb_pkg::ST_IDLE) begin
      if (scl_rise && q.bit_cnt < lbb_pkg::ACK_BIT) begin
        d.shreg = {q.shreg[6:0], q.sda_s2};
        d.bit_cnt = q.bit_cnt + 4'h1;
      end else if (scl_fall && q.bit_cnt == lbb_pkg::ACK_BIT) begin
        // byte complete: pull ack low before the ninth pulse rises
        d.bit_cnt = lbb_pkg::ACK_DONE;
        unique case (q.st)
          lbb_pkg::ST_ADDR: begin
            // write-only: a read address is ignored like a foreign one
            if (rx_byte[7:1] == SLV_ADDR && !rx_byte[0]) begin
              d.st = lbb_pkg::ST_DATA;
              d.ack_oe = 1'b1;
            end else begin
              d.st = lbb_pkg::ST_SKIP;
            end
          end
          lbb_pkg::ST_DATA: begin
            d.last_byte = rx_byte;
            // only the device whose subaddress matches answers
            d.ack_oe = q.subaddr_cnt == q.sub_s2;
            if (rx_byte[7:4] == lbb_pkg::OP_MODE_SET) begin
              d.disp_en = rx_byte[3];
              d.mode = rx_byte[1:0];
            end
            if (rx_byte[7:3] == lbb_pkg::OP_DEV_SEL) begin
              d.subaddr_cnt = rx_byte[2:0];
            end
            if (rx_byte[7:2] == lbb_pkg::OP_BANK_SEL && banked) begin
              d.in_bank = rx_byte[1];
              d.out_bank = rx_byte[0];
            end
            if (rx_byte[7:3] == lbb_pkg::OP_BLINK_SEL) begin
              d.blink_alt = rx_byte[2];
              d.blink_rate = rx_byte[1:0];
            end
          end
          lbb_pkg::ST_SKIP: d.ack_oe = 1'b0;
          lbb_pkg::ST_IDLE: d.ack_oe = 1'b0;
        endcase
      end else if (scl_fall && q.bit_cnt == lbb_pkg::ACK_DONE) begin
        d.ack_oe = 1'b0; // release after the ninth pulse
        d.bit_cnt = 4'h0;
      end
    end else begin
      d.ack_oe = 1'b0;
    end

    // display clock: one-cycle enable from a divider of pclk
    d.tick = 1'b0;
    if (q.div_cnt >= DISP_DIV - 16'h0001) begin
      d.div_cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 16'h0001;
    end

    // multiplex phase advances once per display clock
    if (q.tick) begin
      d.phase = (cur_phase >= last_phase) ? 2'h0 : cur_phase + 2'h1;
    end else begin
      d.phase = cur_phase;
    end

    // blink counter toggles phase each half period of the chosen ratio
    if (!blinking) begin
      d.blink_cnt = 12'h000;
      d.blink_ph = 1'b0;
    end else if (q.tick) begin
      if (q.blink_cnt >= blink_half(q.blink_rate) - 12'h001) begin
        d.blink_cnt = 12'h000;
        d.blink_ph = ~q.blink_ph;
      end else begin
        d.blink_cnt = q.blink_cnt + 12'h001;
      end
    end

    // row presented to the display register
    if (banked) begin
      d.row_sel = (eff_bank ? lbb_pkg::ALT_ROW : 2'h0) + cur_phase;
      d.in_row = q.in_bank ? lbb_pkg::ALT_ROW : 2'h0;
    end else begin
      d.row_sel = cur_phase;
      d.in_row = 2'h0;
    end
    // normal blinking blanks the display in the second half of the period
    d.disp_vis = q.disp_en & ~(~q.blink_alt & blinking & q.blink_ph);

    // apb: answer one cycle after setup, writes act in the access cycle
    d.pready = psel & ~penable & ~q.pready;
    if (psel && !penable) begin
      d.pslverr = 1'b0;
      d.prdata = 32'h00000000;
      unique case (paddr)
        lbb_pkg::CTRL_OFS: begin
          d.prdata[7:0] = {q.blink_rate, q.blink_alt, q.out_bank, q.in_bank, q.disp_en, q.mode};
        end
        lbb_pkg::STAT_OFS: begin
          d.prdata[7:0] = {q.subaddr_cnt, q.st != lbb_pkg::ST_IDLE, q.ack_oe, q.blink_ph,
                           q.row_sel};
        end
        lbb_pkg::RXB_OFS: d.prdata[7:0] = q.last_byte;
        default: d.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == lbb_pkg::CTRL_OFS) begin
      d.mode = pwdata[1:0];
      d.disp_en = pwdata[2];
      if (has_banks(pwdata[1:0])) begin
        d.in_bank = pwdata[3];
        d.out_bank = pwdata[4];
      end
      d.blink_alt = pwdata[5];
      d.blink_rate = pwdata[7:6];
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.st <= lbb_pkg::ST_IDLE;
      q.mode <= lbb_pkg::MODE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign ack_output_pin = q.shreg[0] & 1'b0; // open drain: only ever drives low
  assign ack_output_pin_oe = q.ack_oe;
  assign row_sel = q.row_sel;
  assign disp_visible = q.disp_vis;
  assign in_row_base = q.in_row;

  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
  endsequence

  sequence s_byte_done;
    scl_fall && q.bit_cnt == lbb_pkg::ACK_BIT && q.st == lbb_pkg::ST_DATA;
  endsequence

  // ninth pulse high with the ack pulled and no bus condition in flight
  sequence s_ack_high;
    q.ack_oe && q.bit_cnt == lbb_pkg::ACK_DONE && q.scl_s2 && !start_det && !stop_det;
  endsequence

  property p_start_addr;
    @(posedge pclk) disable iff (!presetn) s_start |=> q.st == lbb_pkg::ST_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    @(posedge pclk) disable iff (!presetn) stop_det |=> q.st == lbb_pkg::ST_IDLE && !q.ack_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn) q.st == lbb_pkg::ST_IDLE |-> !ack_output_pin_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("ack driven while idle");

  property p_ack_timing;
    @(posedge pclk) disable iff (!presetn) s_ack_high |=> q.ack_oe;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack dropped early");

  property p_static_row;
    @(posedge pclk) disable iff (!presetn)
      q.mode == lbb_pkg::MODE_STATIC && $past(q.mode) == lbb_pkg::MODE_STATIC |->
        row_sel == (($past(eff_bank)) ? 2'h2 : 2'h0);
  endproperty
  a_static_row: assert property (p_static_row) else $error("static row wrong");

  property p_mux4_step;
    @(posedge pclk) disable iff (!presetn)
      q.tick && q.mode == lbb_pkg::MODE_MUX4 |=> q.phase == $past(q.phase) + 2'h1;
  endproperty
  a_mux4_step: assert property (p_mux4_step) else $error("phase did not step");

  property p_mux3_wrap;
    @(posedge pclk) disable iff (!presetn)
      q.tick && q.mode == lbb_pkg::MODE_MUX3 |=> q.phase != 2'h3;
  endproperty
  a_mux3_wrap: assert property (p_mux3_wrap) else $error("phase 3 in three-row mode");

  property p_blank_half;
    @(posedge pclk) disable iff (!presetn)
      !q.blink_alt && blinking && q.blink_ph |=> !disp_visible;
  endproperty
  a_blank_half: assert property (p_blank_half) else $error("display not blanked");

  property p_data_ack;
    @(posedge pclk) disable iff (!presetn)
      s_byte_done |=> q.ack_oe == ($past(q.subaddr_cnt) == $past(q.sub_s2));
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data ack wrong");

  property p_skip_quiet;
    @(posedge pclk) disable iff (!presetn) q.st == lbb_pkg::ST_SKIP |-> !q.ack_oe;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("ack for foreign address");

  property p_in_row;
    @(posedge pclk) disable iff (!presetn)
      banked && q.in_bank |=> in_row_base == lbb_pkg::ALT_ROW;
  endproperty
  a_in_row: assert property (p_in_row) else $error("input bank not applied");

  property p_mux2_rows;
    @(posedge pclk) disable iff (!presetn)
      q.mode == lbb_pkg::MODE_MUX2 && !eff_bank |=> row_sel <= 2'h1;
  endproperty
  a_mux2_rows: assert property (p_mux2_rows) else $error("two-row mode left rows 0/1");

endmodule : lbb_top

// File: tb/lbb_i2c_master.sv
// two-wire bus master model for the serial slave receiver
`timescale 1ns/1ps

module lbb_i2c_master (
  // clock
  input wire logic pclk,
  // bus lines, data is pulled up when released
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  localparam int HALF = 8;

  // both lines rest high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold

  // entered idle or between bytes with clock low
  task automatic start();
    sda_drv <= 1'b1;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_drv <= 1'b0;
    hold(HALF);
    scl <= 1'b0;
    hold(HALF);
  endtask : start

  task automatic stop();
    sda_drv <= 1'b0;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_drv <= 1'b1;
    hold(HALF);
  endtask : stop

  // data moves only while clock is low, msb first
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic a1;
    logic a2;
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      hold(HALF);
      scl <= 1'b1;
      hold(HALF);
      scl <= 1'b0;
    end
    sda_drv <= 1'b1;
    hold(HALF);
    scl <= 1'b1;
    hold(1);
    a1 = sda_line;
    hold(HALF - 2);
    a2 = sda_line;
    hold(1);
    scl <= 1'b0;
    hold(HALF);
    // low at both ends of the high phase counts as held
    acked = (a1 === 1'b0) && (a2 === 1'b0);
  endtask : send_byte
endmodule : lbb_i2c_master

// File: tb/lbb_top_bench.sv
// self-checking bench for the lcd bank/blink serial slave
`timescale 1ns/1ps

module lbb_top_bench;
  localparam logic [15:0] DIV = 16'h4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rdy_err, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic scl, m_sda, sda_w, ack_o, ack_oe, disp_visible;
  logic [2:0] straps;
  logic [1:0] row_sel, in_row_base;
  logic [11:0] rt;
  int failures, checked;

  // open-drain ack pin tied to the pulled-up data line
  assign sda_w = m_sda & ~ack_oe;
  always #5 pclk = ~pclk;

  lbb_top #(.DISP_DIV(DIV)) lbb_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl(scl), .sda(sda_w), .ack_output_pin(ack_o), .ack_output_pin_oe(ack_oe),
    .hw_subaddr_bit0(straps[0]), .hw_subaddr_bit1(straps[1]), .hw_subaddr_bit2(straps[2]),
    .row_sel(row_sel), .disp_visible(disp_visible), .in_row_base(in_row_base)
  );
  lbb_i2c_master lbb_i2c_master_i (.pclk(pclk), .sda_line(sda_w), .scl(scl), .sda_drv(m_sda));

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic timeout();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask : timeout

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    rdy_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) timeout();
  endtask : apb

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic ib, ob, al,
                                      input logic [1:0] r);
    return {24'h0, r, al, ob, ib, 1'b1, m};
  endfunction : ctl

  function automatic logic [1:0] nxt(input logic [1:0] p, input logic [3:0] m);
    for (int k = 1; k < 4; k++) if (m[2'(p + k)]) return 2'(p + k);
    return p;
  endfunction : nxt

  // rows seen must be exactly the mask, stepping in order
  task automatic watch_rows(input logic [3:0] m, input int n);
    logic [3:0] seen;
    logic [1:0] prev;
    int bad;
    seen = 4'h0;
    bad = 0;
    repeat (20) @(posedge pclk);
    prev = row_sel;
    repeat (n) begin
      @(posedge pclk);
      seen[row_sel] = 1'b1;
      if (row_sel !== prev && row_sel !== nxt(prev, m)) bad++;
      prev = row_sel;
    end
    chk(32'(seen), 32'(m));
    chk(bad, 0);
  endtask : watch_rows

  task automatic run_mode(input logic [31:0] c, input logic [3:0] m, input logic [1:0] ib);
    apb(1'b1, lbb_pkg::CTRL_OFS, c);
    watch_rows(m, 60);
    chk(32'(in_row_base), 32'(ib));
  endtask : run_mode

  task automatic wait_vis(input logic v);
    for (int i = 0; i < 20000; i++) begin
      @(posedge pclk);
      if (disp_visible === v) return;
    end
    timeout();
  endtask : wait_vis

  // a full shown half of the blink period, in pclk cycles
  task automatic blink_half(input logic [31:0] exp);
    int c;
    c = 0;
    wait_vis(1'b0);
    wait_vis(1'b1);
    while (disp_visible === 1'b1 && c < 20000) begin
      @(posedge pclk);
      c++;
    end
    chk(c, exp);
  endtask : blink_half

  task automatic send(input logic [7:0] b, input logic exp_ack);
    lbb_i2c_master_i.send_byte(b, ok);
    chk(32'(ok), 32'(exp_ack));
  endtask : send

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, straps} = '0;
    failures = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lbb_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({disp_visible, in_row_base, ack_oe}, 32'h0);
    apb(1'b1, 8'h0C, 32'hFF);
    chk(32'(rdy_err), 32'h1);
    apb(1'b0, lbb_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test reset and unmapped done");
    run_mode(ctl(lbb_pkg::MODE_MUX4, 0, 0, 0, 0), 4'hF, 2'h0);
    run_mode(ctl(lbb_pkg::MODE_MUX3, 1, 1, 0, 0), 4'h7, 2'h0);
    run_mode(ctl(lbb_pkg::MODE_MUX2, 0, 0, 0, 0), 4'h3, 2'h0);
    run_mode(ctl(lbb_pkg::MODE_STATIC, 0, 0, 0, 0), 4'h1, 2'h0);
    chk(32'(disp_visible), 32'h1);
    run_mode(ctl(lbb_pkg::MODE_STATIC, 0, 1, 0, 0), 4'h4, 2'h0);
    run_mode(ctl(lbb_pkg::MODE_STATIC, 1, 0, 0, 0), 4'h1, 2'h2);
    run_mode(ctl(lbb_pkg::MODE_MUX2, 1, 1, 0, 0), 4'hC, 2'h2);
    $display("test row selection done");
    for (int r = 1; r < 4; r++) begin
      apb(1'b1, lbb_pkg::CTRL_OFS, ctl(lbb_pkg::MODE_STATIC, 0, 0, 0, 2'(r)));
      rt = (r == 1) ? lbb_pkg::BLINK_RATIO1 :
           (r == 2) ? lbb_pkg::BLINK_RATIO2 : lbb_pkg::BLINK_RATIO3;
      blink_half(32'(rt) / 2 * 32'(DIV));
    end
    $display("test blink rates done");
    // host-made blinking: the enable bit toggled by hand
    apb(1'b1, lbb_pkg::CTRL_OFS, ctl(lbb_pkg::MODE_STATIC, 0, 0, 0, 0));
    repeat (2) @(posedge pclk);
    chk(32'(disp_visible), 32'h1);
    apb(1'b1, lbb_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(disp_visible), 32'h0);
    lbb_i2c_master_i.start();
    send(8'h70, 1'b1);
    send(8'hC9, 1'b1);
    send(8'hFB, 1'b1);
    send(8'hF5, 1'b1);
    lbb_i2c_master_i.stop();
    chk({ack_o, ack_oe}, 32'h0);
    apb(1'b0, lbb_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h7D);
    apb(1'b0, lbb_pkg::RXB_OFS, 32'h0);
    chk(rd, 32'hF5);
    chk(32'(in_row_base), 32'h2);
    watch_rows(4'h5, 3500);
    lbb_i2c_master_i.start();
    send(8'h72, 1'b0);
    send(8'hC8, 1'b0);
    lbb_i2c_master_i.start();
    send(8'h71, 1'b0);
    lbb_i2c_master_i.stop();
    apb(1'b0, lbb_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h7D);
    // subaddress counter moved away from the straps, then straps follow it
    lbb_i2c_master_i.start();
    send(8'h70, 1'b1);
    send(8'hE1, 1'b1);
    send(8'hF5, 1'b0);
    lbb_i2c_master_i.stop();
    apb(1'b0, lbb_pkg::STAT_OFS, 32'h0);
    chk(rd & 32'hE0, 32'h20);
    straps <= 3'h1;
    lbb_i2c_master_i.start();
    send(8'h70, 1'b1);
    send(8'hF5, 1'b1);
    lbb_i2c_master_i.stop();
    $display("test serial commands done");
    final_report();
  end
endmodule : lbb_top_bench
